// ===== hw/ptoc_regs.vh
`ifndef PTOC_REGS_VH
`define PTOC_REGS_VH

// register byte offsets of the global words, then the instance block and word select address fields
`define PTOC_OFS_CTRL 8'h00
`define PTOC_OFS_STATUS 8'h04
`define PTOC_OFS_MASK 8'h08
`define PTOC_OFS_LIVE 8'h0C
`define PTOC_OFS_INST0 2'h1
`define PTOC_OFS_INST1 2'h2
`define PTOC_OFS_PICKUP 2'h0
`define PTOC_OFS_CURVE 2'h1
`define PTOC_OFS_TIMING 2'h2
`define PTOC_OFS_TORQUE 2'h3

// status / mask bit positions, instance 1 sits STAT_INST_STRIDE bits higher
`define PTOC_STAT_PICKUP 0
`define PTOC_STAT_TIMEOUT 1
`define PTOC_STAT_RESET 2
`define PTOC_STAT_INST_STRIDE 4
`define PTOC_STAT_REJECT 8
`define PTOC_STAT_USED 32'h0000_0177

// field layouts
`define PTOC_CTRL_DIR_BIT 2
`define PTOC_CURVE_DIAL_LSB 4
`define PTOC_CURVE_EM_BIT 15
`define PTOC_TIMING_MR_LSB 8
`define PTOC_TIMING_UW_LSB 16

// reset values
`define PTOC_RST_COUNT 2'h1
`define PTOC_RST_PICKUP 9'h064
`define PTOC_RST_CURVE 4'h2
`define PTOC_RST_DIAL 11'h064
`define PTOC_RST_USER_WEIGHT 8'h10
`define PTOC_RST_TORQUE 2'h1

// setting ranges: current in 0.01 A, dial in 0.01, times in quarter power cycles
`define PTOC_PICKUP_MIN 9'd10
`define PTOC_PICKUP_MAX 9'd320
`define PTOC_DIAL_US_MIN 11'd50
`define PTOC_DIAL_US_MAX 11'd1500
`define PTOC_DIAL_IEC_MIN 11'd5
`define PTOC_DIAL_IEC_MAX 11'd100
`define PTOC_DIAL_RC_MIN 11'd10
`define PTOC_DIAL_RC_MAX 11'd200
`define PTOC_TIME_MAX 8'd240
`define PTOC_CURVE_IEC_FIRST 4'd5
`define PTOC_CURVE_RECLOSER 4'd10
`define PTOC_CURVE_USER 4'd11
`define PTOC_TORQUE_TRUE 2'h1
`define PTOC_TORQUE_BIT 2'h2

// timing: one processing interval is a quarter power cycle (60 Hz)
`define PTOC_CLK_PERIOD_NS 100
`define PTOC_INTERVAL_NS 4166667
`define PTOC_INTERVAL_CLKS (`PTOC_INTERVAL_NS / `PTOC_CLK_PERIOD_NS)
`define PTOC_DROPOUT_TICKS 3'd4
`define PTOC_ACC_UNIT 32'd16

`endif

// ===== hw/ptoc_elem.v
`timescale 1ns/100ps
`include "ptoc_regs.vh"

module ptoc_elem (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_tick,
  input wire i_enable,
  input wire i_gate,
  input wire [15:0] i_ip,
  input wire [8:0] i_pickup,
  input wire [7:0] i_weight,
  input wire [10:0] i_dial,
  input wire i_em_reset,
  input wire [7:0] i_adder,
  input wire [7:0] i_min_resp,
  output reg o_picked_up,
  output reg o_timed_out,
  output reg o_fully_reset
);

  reg [31:0] acc_r;
  reg [7:0] elapsed_r;
  reg [7:0] add_cnt_r;
  reg [2:0] drop_cnt_r;
  reg [31:0] acc_nxt;

  // an open gate shows the comparator and timers zero current
  wire [15:0] ip_eff = i_gate ? i_ip : 16'h0000;
  wire above = ip_eff > {7'h00, i_pickup};
  wire [15:0] excess = ip_eff - {7'h00, i_pickup};
  // product sized to its full 24 bits before widening, so heavy faults do not wrap
  wire [23:0] inc_prod = i_weight * excess;
  wire [31:0] inc = {8'h00, inc_prod};
  wire [31:0] dec = {15'h0000, i_weight * {8'h00, i_pickup}};
  // dial stretches the full scale only, never the adder or clamp
  wire [31:0] full = i_dial * i_pickup * `PTOC_ACC_UNIT;
  wire curve_done = acc_r >= full;
  wire adder_done = add_cnt_r >= i_adder;
  wire clamp_done = elapsed_r >= i_min_resp;
  wire [32:0] acc_sum = {1'b0, acc_r} + {1'b0, inc};

  // next accumulator value for this interval
  always @* begin
    acc_nxt = acc_r;
    if (above) begin
      if (acc_sum[31:0] >= full || acc_sum[32])
        acc_nxt = full;
      else
        acc_nxt = acc_sum[31:0];
    end else if (i_em_reset) begin
      acc_nxt = (acc_r > dec) ? acc_r - dec : 32'h0000_0000;
    end else if (drop_cnt_r >= `PTOC_DROPOUT_TICKS - 3'd1) begin
      acc_nxt = 32'h0000_0000;
    end
  end

  // all three flags move together, once per interval
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_r <= 32'h0000_0000;
      elapsed_r <= 8'h00;
      add_cnt_r <= 8'h00;
      drop_cnt_r <= 3'h0;
      o_picked_up <= 1'b0;
      o_timed_out <= 1'b0;
      o_fully_reset <= 1'b1;
    end else if (i_tick) begin
      if (!i_enable) begin
        acc_r <= 32'h0000_0000;
        elapsed_r <= 8'h00;
        add_cnt_r <= 8'h00;
        drop_cnt_r <= 3'h0;
        o_picked_up <= 1'b0;
        o_timed_out <= 1'b0;
        o_fully_reset <= 1'b1;
      end else if (above) begin
        acc_r <= acc_nxt;
        drop_cnt_r <= 3'h0;
        if (elapsed_r != 8'hFF)
          elapsed_r <= elapsed_r + 8'h01;
        if (curve_done && add_cnt_r != 8'hFF)
          add_cnt_r <= add_cnt_r + 8'h01;
        o_picked_up <= 1'b1;
        o_timed_out <= curve_done && adder_done && clamp_done;
        o_fully_reset <= 1'b0;
      end else begin
        acc_r <= acc_nxt;
        elapsed_r <= 8'h00;
        add_cnt_r <= 8'h00;
        if (drop_cnt_r != 3'h7)
          drop_cnt_r <= drop_cnt_r + 3'h1;
        o_picked_up <= 1'b0;
        o_timed_out <= 1'b0;
        o_fully_reset <= (acc_nxt == 32'h0000_0000);
      end
    end
  end

endmodule

// ===== hw/ptoc_top.v
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "ptoc_regs.vh"

module ptoc_top #(
  parameter PROC_INTERVAL_CLKS = `PTOC_INTERVAL_CLKS
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire [15:0] i_ia_mag,
  input wire [15:0] i_ib_mag,
  input wire [15:0] i_ic_mag,
  input wire [1:0] i_dir_permit,
  input wire [1:0] i_torque_bit,
  output wire o_phase_toc1_picked_up,
  output wire o_phase_toc1_timed_out,
  output wire o_phase_toc1_fully_reset,
  output wire o_phase_toc2_picked_up,
  output wire o_phase_toc2_timed_out,
  output wire o_phase_toc2_fully_reset,
  output wire o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // settings and bus state

  reg [1:0] toc_instance_count_r;
  reg directional_control_enable_r;
  reg [31:0] status_r;
  reg [31:0] mask_r;
  reg [8:0] pickup_r [0:1];
  reg [3:0] curve_r [0:1];
  reg [10:0] dial_r [0:1];
  reg em_reset_r [0:1];
  reg [7:0] adder_r [0:1];
  reg [7:0] min_resp_r [0:1];
  reg [7:0] user_weight_r [0:1];
  reg [1:0] torque_r [0:1];
  reg ack_r;
  reg [31:0] tick_cnt_r;
  reg tick_r;
  reg [5:0] flags_prev_r;
  reg [31:0] rd_val;
  reg [15:0] ip_max;
  reg reject;
  reg [31:0] stat_nxt;
  integer k;

  wire [5:0] flags;
  wire [1:0] gate;
  wire [1:0] enable;
  wire [7:0] weight0;
  wire [7:0] weight1;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // relative rate of each curve; the steeper the curve, the larger the weight
  function [7:0] curve_weight;
    input [3:0] curve;
    input [7:0] user_w;
    begin
      case (curve)
        4'd0: curve_weight = 8'd8;
        4'd1: curve_weight = 8'd12;
        4'd2: curve_weight = 8'd16;
        4'd3: curve_weight = 8'd24;
        4'd4: curve_weight = 8'd32;
        4'd5: curve_weight = 8'd6;
        4'd6: curve_weight = 8'd10;
        4'd7: curve_weight = 8'd20;
        4'd8: curve_weight = 8'd28;
        4'd9: curve_weight = 8'd40;
        4'd10: curve_weight = 8'd64;
        default: curve_weight = user_w;
      endcase
    end
  endfunction

  // dial limits follow the family of the curve written with it
  function dial_ok;
    input [3:0] curve;
    input [10:0] dial;
    begin
      if (curve < `PTOC_CURVE_IEC_FIRST)
        dial_ok = (dial >= `PTOC_DIAL_US_MIN) && (dial <= `PTOC_DIAL_US_MAX);
      else if (curve < `PTOC_CURVE_RECLOSER)
        dial_ok = (dial >= `PTOC_DIAL_IEC_MIN) && (dial <= `PTOC_DIAL_IEC_MAX);
      else
        dial_ok = (dial >= `PTOC_DIAL_RC_MIN) && (dial <= `PTOC_DIAL_RC_MAX);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operating quantity and torque gates

  // largest phase magnitude, shared by both instances
  always @* begin
    ip_max = i_ia_mag;
    if (i_ib_mag > ip_max)
      ip_max = i_ib_mag;
    if (i_ic_mag > ip_max)
      ip_max = i_ic_mag;
  end

  // gate per instance; a disabled directional unit always permits
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gate_gen
      wire permit = i_dir_permit[g] | ~directional_control_enable_r;
      wire torque_true = (torque_r[g] == `PTOC_TORQUE_TRUE) ||
                         ((torque_r[g] == `PTOC_TORQUE_BIT) && i_torque_bit[g]);
      assign gate[g] = permit & torque_true;
    end
  endgenerate

  assign enable[0] = (toc_instance_count_r == 2'd1) || (toc_instance_count_r == 2'd2);
  assign enable[1] = (toc_instance_count_r == 2'd2);
  assign weight0 = curve_weight(curve_r[0], user_weight_r[0]);
  assign weight1 = curve_weight(curve_r[1], user_weight_r[1]);

  // processing interval strobe; both instances share it so they stay aligned
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r >= PROC_INTERVAL_CLKS - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the two elements

  ptoc_elem u_elem0 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_r),
    .i_enable(enable[0]),
    .i_gate(gate[0]),
    .i_ip(ip_max),
    .i_pickup(pickup_r[0]),
    .i_weight(weight0),
    .i_dial(dial_r[0]),
    .i_em_reset(em_reset_r[0]),
    .i_adder(adder_r[0]),
    .i_min_resp(min_resp_r[0]),
    .o_picked_up(flags[0]),
    .o_timed_out(flags[1]),
    .o_fully_reset(flags[2])
  );

  ptoc_elem u_elem1 (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_tick(tick_r),
    .i_enable(enable[1]),
    .i_gate(gate[1]),
    .i_ip(ip_max),
    .i_pickup(pickup_r[1]),
    .i_weight(weight1),
    .i_dial(dial_r[1]),
    .i_em_reset(em_reset_r[1]),
    .i_adder(adder_r[1]),
    .i_min_resp(min_resp_r[1]),
    .o_picked_up(flags[3]),
    .o_timed_out(flags[4]),
    .o_fully_reset(flags[5])
  );

  assign o_phase_toc1_picked_up = flags[0];
  assign o_phase_toc1_timed_out = flags[1];
  assign o_phase_toc1_fully_reset = flags[2];
  assign o_phase_toc2_picked_up = flags[3];
  assign o_phase_toc2_timed_out = flags[4];
  assign o_phase_toc2_fully_reset = flags[5];

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, answer on the second cycle

  wire req = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ack_r;
  wire inst_hit = (i_avs_address[7:6] == 2'b00) &&
                  ((i_avs_address[5:4] == `PTOC_OFS_INST0) || (i_avs_address[5:4] == `PTOC_OFS_INST1));
  wire idx = (i_avs_address[5:4] == `PTOC_OFS_INST1);
  wire [1:0] sub = i_avs_address[3:2];
  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wr_val = (rd_val & ~be_mask) | (i_avs_writedata & be_mask);

  assign o_avs_waitrequest = req & ~ack_r;

  // current value of the addressed word; unmapped words read zero
  always @* begin
    rd_val = 32'h0000_0000;
    if (inst_hit) begin
      case (sub)
        `PTOC_OFS_PICKUP: rd_val = {23'h000000, pickup_r[idx]};
        `PTOC_OFS_CURVE: rd_val = {16'h0000, em_reset_r[idx], dial_r[idx], curve_r[idx]};
        `PTOC_OFS_TIMING: rd_val = {8'h00, user_weight_r[idx], min_resp_r[idx], adder_r[idx]};
        default: rd_val = {30'h00000000, torque_r[idx]};
      endcase
    end else begin
      case (i_avs_address)
        `PTOC_OFS_CTRL: rd_val = {29'h00000000, directional_control_enable_r, toc_instance_count_r};
        `PTOC_OFS_STATUS: rd_val = status_r;
        `PTOC_OFS_MASK: rd_val = mask_r;
        `PTOC_OFS_LIVE: rd_val = {ip_max, 7'h00, gate, flags[5:3], 1'b0, flags[2:0]};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // range checks on the merged word; a refused write keeps the old setting
  always @* begin
    reject = 1'b0;
    if (wr_go) begin
      if (inst_hit) begin
        case (sub)
          `PTOC_OFS_PICKUP: reject = (wr_val[8:0] < `PTOC_PICKUP_MIN) || (wr_val[8:0] > `PTOC_PICKUP_MAX);
          `PTOC_OFS_CURVE: reject = (wr_val[3:0] > `PTOC_CURVE_USER) ||
                                    !dial_ok(wr_val[3:0], wr_val[14:4]);
          `PTOC_OFS_TIMING: reject = (wr_val[7:0] > `PTOC_TIME_MAX) || (wr_val[15:8] > `PTOC_TIME_MAX);
          default: reject = (wr_val[1:0] != `PTOC_TORQUE_TRUE) && (wr_val[1:0] != `PTOC_TORQUE_BIT);
        endcase
      end else if (i_avs_address == `PTOC_OFS_CTRL) begin
        reject = (wr_val[1:0] != 2'd1) && (wr_val[1:0] != 2'd2);
      end
    end
  end

  // bus handshake and read data
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (i_avs_read & ~ack_r)
        o_avs_readdata <= rd_val;
    end
  end

  // settings written on the accepting edge
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      toc_instance_count_r <= `PTOC_RST_COUNT;
      directional_control_enable_r <= 1'b0;
      mask_r <= 32'h0000_0000;
      for (k = 0; k < 2; k = k + 1) begin
        pickup_r[k] <= `PTOC_RST_PICKUP;
        curve_r[k] <= `PTOC_RST_CURVE;
        dial_r[k] <= `PTOC_RST_DIAL;
        em_reset_r[k] <= 1'b0;
        adder_r[k] <= 8'h00;
        min_resp_r[k] <= 8'h00;
        user_weight_r[k] <= `PTOC_RST_USER_WEIGHT;
        torque_r[k] <= `PTOC_RST_TORQUE;
      end
    end else if (wr_go && !reject) begin
      if (inst_hit) begin
        case (sub)
          `PTOC_OFS_PICKUP: pickup_r[idx] <= wr_val[8:0];
          `PTOC_OFS_CURVE: begin
            curve_r[idx] <= wr_val[3:0];
            dial_r[idx] <= wr_val[14:4];
            em_reset_r[idx] <= wr_val[`PTOC_CURVE_EM_BIT];
          end
          `PTOC_OFS_TIMING: begin
            adder_r[idx] <= wr_val[7:0];
            min_resp_r[idx] <= wr_val[15:8];
            user_weight_r[idx] <= wr_val[23:16];
          end
          default: torque_r[idx] <= wr_val[1:0];
        endcase
      end else begin
        case (i_avs_address)
          `PTOC_OFS_CTRL: begin
            toc_instance_count_r <= wr_val[1:0];
            directional_control_enable_r <= wr_val[`PTOC_CTRL_DIR_BIT];
          end
          `PTOC_OFS_MASK: mask_r <= wr_val & `PTOC_STAT_USED;
          default: mask_r <= mask_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: rising flags and refused writes, write one to clear

  wire [5:0] flag_rise = flags & ~flags_prev_r;
  wire stat_wr = wr_go && !inst_hit && (i_avs_address == `PTOC_OFS_STATUS);

  // a new event beats a clear landing in the same cycle
  always @* begin
    stat_nxt = status_r;
    if (stat_wr)
      stat_nxt = status_r & ~(i_avs_writedata & be_mask);
    stat_nxt[2:0] = stat_nxt[2:0] | flag_rise[2:0];
    stat_nxt[`PTOC_STAT_INST_STRIDE + 2:`PTOC_STAT_INST_STRIDE] =
      stat_nxt[`PTOC_STAT_INST_STRIDE + 2:`PTOC_STAT_INST_STRIDE] | flag_rise[5:3];
    if (reject)
      stat_nxt[`PTOC_STAT_REJECT] = 1'b1;
  end

  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_r <= 32'h0000_0000;
      flags_prev_r <= 6'b100100;
    end else begin
      status_r <= stat_nxt & `PTOC_STAT_USED;
      flags_prev_r <= flags;
    end
  end

  assign o_irq = |(status_r & mask_r);

endmodule

// ===== test/ptoc_meas_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// phase magnitude front end: one registered result set per clock, like
// a measurement filter updating its output registers
module ptoc_meas_model (
  input wire i_core_clk,
  input wire i_nrst,
  input wire [15:0] i_ia_set,
  input wire [15:0] i_ib_set,
  input wire [15:0] i_ic_set,
  output reg [15:0] o_ia_mag,
  output reg [15:0] o_ib_mag,
  output reg [15:0] o_ic_mag
);
  // results read zero until the filter has run after reset
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {o_ia_mag, o_ib_mag, o_ic_mag} <= 48'h0;
    end else begin
      {o_ia_mag, o_ib_mag, o_ic_mag} <= {i_ia_set, i_ib_set, i_ic_set};
    end
  end
endmodule

// ===== test/ptoc_top_assertions.sv
`timescale 1ns/100ps
module ptoc_top_chk #(
  parameter PROC_INTERVAL_CLKS = 4
) (
  input wire i_core_clk,
  input wire i_nrst,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  input wire o_phase_toc1_picked_up,
  input wire o_phase_toc1_timed_out,
  input wire o_phase_toc1_fully_reset,
  input wire o_phase_toc2_picked_up,
  input wire o_phase_toc2_timed_out,
  input wire o_phase_toc2_fully_reset,
  input wire o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire [5:0] flags = {o_phase_toc2_fully_reset, o_phase_toc2_timed_out, o_phase_toc2_picked_up,
    o_phase_toc1_fully_reset, o_phase_toc1_timed_out, o_phase_toc1_picked_up};
  reg [5:0] flags_r;
  reg [31:0] since_chg_r;
  // cycles since any flag moved; a flag move off the interval grid is a hazard for trip logic
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_r <= 6'h24;
      since_chg_r <= 32'h0;
    end else begin
      flags_r <= flags;
      since_chg_r <= (flags != flags_r) ? 32'h0 : since_chg_r + 32'h1;
    end
  end
  chk_flag_spacing: assert property ((flags != flags_r) |-> (since_chg_r >= PROC_INTERVAL_CLKS - 1))
    else $error("flags moved inside one interval");
  chk_timeout_pickup1: assert property (o_phase_toc1_timed_out |-> o_phase_toc1_picked_up)
    else $error("element 1 timed out without pickup");
  chk_timeout_pickup2: assert property (o_phase_toc2_timed_out |-> o_phase_toc2_picked_up)
    else $error("element 2 timed out without pickup");
  chk_reset_excl1: assert property (o_phase_toc1_fully_reset |-> !o_phase_toc1_picked_up)
    else $error("element 1 reset while picked up");
  chk_reset_excl2: assert property (o_phase_toc2_fully_reset |-> !o_phase_toc2_picked_up)
    else $error("element 2 reset while picked up");
  chk_wait_once: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("bus answer not after one wait state");
  chk_wait_cause: assert property (o_avs_waitrequest |-> (i_avs_read || i_avs_write))
    else $error("waitrequest without request");
  chk_rdata_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest))
    else $error("read data moved without a read");
  cover property ($rose(o_phase_toc1_timed_out));
  cover property ($rose(o_phase_toc2_picked_up));
  cover property ($rose(o_irq));
  cover property (i_avs_read && !o_avs_waitrequest);
endmodule

bind ptoc_top ptoc_top_chk #(.PROC_INTERVAL_CLKS(PROC_INTERVAL_CLKS)) u_chk (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_phase_toc1_picked_up(o_phase_toc1_picked_up), .o_phase_toc1_timed_out(o_phase_toc1_timed_out),
  .o_phase_toc1_fully_reset(o_phase_toc1_fully_reset), .o_phase_toc2_picked_up(o_phase_toc2_picked_up),
  .o_phase_toc2_timed_out(o_phase_toc2_timed_out), .o_phase_toc2_fully_reset(o_phase_toc2_fully_reset),
  .o_irq(o_irq));

// ===== test/ptoc_top_tb_top.sv
`timescale 1ns/100ps
module ptoc_top_tb_top;
  localparam integer PI = 4;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wreq;
  logic irq;
  logic [15:0] ia_s = 16'h0;
  logic [15:0] ib_s = 16'h0;
  logic [15:0] ic_s = 16'h0;
  logic [15:0] ia;
  logic [15:0] ib;
  logic [15:0] ic;
  logic [1:0] permit = 2'h3;
  logic [1:0] tq = 2'h3;
  wire [5:0] flg;
  integer num_errors = 0;
  integer n_tests = 0;
  integer i, c, t0, t1;
  // register walk: write flag, address, data, expected read-back
  logic [26:0] wm = 27'h6FFFF80;
  logic [7:0] ta [27] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40, 8'h1C, 8'h10, 8'h10, 8'h10,
    8'h10, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h18, 8'h18, 8'h18, 8'h14, 8'h10, 8'h04,
    8'h04, 8'h40};
  logic [31:0] td [27] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h9, 32'h141, 32'h140,
    32'hA, 32'h310, 32'h055, 32'h655, 32'hC8A, 32'hC9B, 32'h5DC0, 32'h5DD0, 32'hF1, 32'h1000F0, 32'h10F100,
    32'h322, 32'h64, 32'h0, 32'h100, 32'hFF};
  logic [31:0] te [27] = '{32'h1, 32'h64, 32'h642, 32'h100000, 32'h1, 32'h64, 32'h0, 32'h1, 32'h64, 32'h64,
    32'h140, 32'hA, 32'h642, 32'h055, 32'h055, 32'hC8A, 32'hC8A, 32'h5DC0, 32'h5DC0, 32'h100000, 32'h1000F0,
    32'h1000F0, 32'h322, 32'h64, 32'h100, 32'h0, 32'h0};

  // 10 MHz core clock
  always #50 clk = ~clk;

  ptoc_meas_model u_meas (.i_core_clk(clk), .i_nrst(nrst), .i_ia_set(ia_s), .i_ib_set(ib_s),
    .i_ic_set(ic_s), .o_ia_mag(ia), .o_ib_mag(ib), .o_ic_mag(ic));

  // short interval so curve runs fit the simulation budget
  ptoc_top #(.PROC_INTERVAL_CLKS(PI)) dut (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_ia_mag(ia), .i_ib_mag(ib), .i_ic_mag(ic),
    .i_dir_permit(permit), .i_torque_bit(tq), .o_phase_toc1_picked_up(flg[0]),
    .o_phase_toc1_timed_out(flg[1]), .o_phase_toc1_fully_reset(flg[2]), .o_phase_toc2_picked_up(flg[3]),
    .o_phase_toc2_timed_out(flg[4]), .o_phase_toc2_fully_reset(flg[5]), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    begin
      if (num_errors == 0 && n_tests > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  task automatic hang();
    begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    integer k;
    begin
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (wreq !== 1'b0 && k < 50);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k >= 50) hang();
      @(posedge clk);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, e);
    end
  endtask

  task automatic set_i(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c2);
    begin
      ia_s <= a;
      ib_s <= b;
      ic_s <= c2;
      @(posedge clk);
    end
  endtask

  // bounded wait for one flag; n returns the cycles spent
  task automatic wait_bit(input integer b, input logic v, input integer lim, output integer n);
    begin
      n = 0;
      while (flg[b] !== v && n < lim) begin
        @(posedge clk);
        n = n + 1;
      end
      if (flg[b] !== v) hang();
    end
  endtask

  // full reset, then a heavy fault; t is pickup-to-timeout in cycles
  task automatic run_to(input logic [31:0] tw, output integer t);
    integer n;
    begin
      wreg(8'h18, tw);
      set_i(16'h0000, 16'h0000, 16'h0000);
      wait_bit(2, 1'b1, 12 * PI, n);
      set_i(16'h0BB8, 16'h0005, 16'h0007);
      wait_bit(0, 1'b1, 3 * PI, n);
      wait_bit(1, 1'b1, 400 * PI, t);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("flags after reset", {26'h0, flg}, 32'h24);
    // reset values, range refusals and the sticky refusal bit
    for (i = 0; i < 27; i = i + 1) begin
      if (wm[i]) wreg(ta[i], td[i]);
      rchk($sformatf("reg %h", ta[i]), ta[i], te[i]);
    end
    wreg(8'h08, 32'h1);
    set_i(16'h0000, 16'h0064, 16'h0000);
    repeat (3 * PI) @(posedge clk);
    chk("pickup at threshold", 32'(flg[0]), 32'h0);
    set_i(16'h0000, 16'h0064, 16'h0065);
    wait_bit(0, 1'b1, 3 * PI, c);
    chk("reset while timing", 32'(flg[2]), 32'h0);
    // status latches the rise one edge after the flag itself moves
    @(posedge clk);
    chk("irq on pickup", 32'(irq), 32'h1);
    rchk("status", 8'h04, 32'h1);
    wreg(8'h08, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    wreg(8'h04, 32'h1);
    rchk("status cleared", 8'h04, 32'h0);
    // torque gate follows a status bit, then the directional permit
    wreg(8'h1C, 32'h2);
    tq <= 2'h2;
    wait_bit(0, 1'b0, 3 * PI, c);
    chk("timed with gate open", 32'(flg[1]), 32'h0);
    tq <= 2'h3;
    wait_bit(0, 1'b1, 3 * PI, c);
    wreg(8'h00, 32'h5);
    permit <= 2'h2;
    wait_bit(0, 1'b0, 3 * PI, c);
    wreg(8'h00, 32'h1);
    wait_bit(0, 1'b1, 3 * PI, c);
    permit <= 2'h3;
    // adder and minimum response against the plain curve
    run_to(32'h00100000, t0);
    run_to(32'h00100014, t1);
    chk("adder delay", 32'(t1 - t0 >= 19 * PI && t1 - t0 <= 21 * PI), 32'h1);
    run_to(32'h00102800, t1);
    chk("min response", 32'(t1 >= 39 * PI), 32'h1);
    chk("second disabled", {29'h0, flg[5:3]}, 32'h4);
    wreg(8'h00, 32'h2);
    wait_bit(3, 1'b1, 3 * PI, c);
    rchk("live word", 8'h0C, 32'h0BB80193);
    wreg(8'h00, 32'h0);
    rchk("count refused", 8'h00, 32'h2);
    // non-emulated reset: fully reset three intervals after pickup drops
    set_i(16'h0000, 16'h0000, 16'h0000);
    wait_bit(0, 1'b0, 3 * PI, c);
    chk("timed after drop", 32'(flg[1]), 32'h0);
    wait_bit(2, 1'b1, 8 * PI, c);
    chk("dropout time", c, 32'(3 * PI));
    // emulated reset: full scale bleeds by weight times pickup each interval
    wreg(8'h14, 32'h8322);
    rchk("em setting", 8'h14, 32'h8322);
    run_to(32'h00100000, t0);
    set_i(16'h0000, 16'h0000, 16'h0000);
    wait_bit(0, 1'b0, 3 * PI, c);
    chk("em still resetting", 32'(flg[2]), 32'h0);
    wait_bit(2, 1'b1, 60 * PI, c);
    chk("em reset time", c, 32'(49 * PI));
    report_and_stop();
  end
endmodule
